// [logic/pcs_pkg.sv]
// Constants for PC sequencing, return stack and indirect pointer decode.
// Assumes a single 100 MHz clock domain and an APB register port.
package pcs_pkg;
   localparam int          PC_W          = 15;
   localparam int          STK_DEPTH     = 16;
   localparam int          SP_W          = 5;
   // Register byte addresses (index times four)
   localparam logic [11:0] TOS_LOW_IDX   = 12'hFEE;
   localparam logic [11:0] TOS_HIGH_IDX  = 12'hFEF;
   localparam logic [13:0] ADDR_TOS_LOW  = 14'h3FB8;
   localparam logic [13:0] ADDR_TOS_HIGH = 14'h3FBC;
   localparam logic [13:0] ADDR_STK_PTR  = 14'h0000;
   localparam logic [13:0] ADDR_PC_LOW   = 14'h0004;
   localparam logic [13:0] ADDR_PC_LATCH = 14'h0008;
   localparam logic [13:0] ADDR_LATCH_S  = 14'h000C;
   localparam logic [13:0] ADDR_P0L_S    = 14'h0010;
   localparam logic [13:0] ADDR_P0H_S    = 14'h0014;
   localparam logic [13:0] ADDR_P1L_S    = 14'h0018;
   localparam logic [13:0] ADDR_P1H_S    = 14'h001C;
   localparam logic [13:0] ADDR_STATUS   = 14'h0020;
   localparam logic [13:0] ADDR_CFG      = 14'h0024;
   // Reset values
   localparam logic [4:0]  SP_RESET      = 5'h1F;
   localparam logic [14:0] PC_RESET      = 15'h0000;
   localparam logic        CFG_RESET     = 1'b0;
   // Status field positions
   localparam int          ST_OVF_BIT    = 0;
   localparam int          ST_UNF_BIT    = 1;
   // Indirect decode region bounds
   localparam logic [15:0] TRAD_TOP      = 16'h0FFF;
   localparam logic [15:0] LIN_BASE      = 16'h2000;
   localparam logic [15:0] LIN_TOP       = 16'h29AF;
   localparam logic [6:0]  RAM_BLK       = 7'h50;
   localparam logic [6:0]  RAM_OFS       = 7'h20;
   localparam logic [6:0]  IND0_ADR      = 7'h00;
   localparam logic [6:0]  IND1_ADR      = 7'h01;
   // Extra cycle for program memory indirect access
   localparam int          PM_EXTRA_CYC  = 1;

   typedef enum logic [2:0] {
      PCS_OP_NONE = 3'h0, PCS_OP_PCLOW = 3'h1, PCS_OP_CALL = 3'h2,
      PCS_OP_CCALL = 3'h3, PCS_OP_AJMP = 3'h4, PCS_OP_SJMP = 3'h5,
      PCS_OP_RET  = 3'h6, PCS_OP_IRQ  = 3'h7
   } pcs_op_e;

   typedef enum logic [1:0] {
      PCS_REG_TRAD = 2'h0, PCS_REG_LIN = 2'h1, PCS_REG_PM = 2'h3, PCS_REG_NONE = 2'h2
   } pcs_region_e;
endpackage : pcs_pkg

// [logic/pcs_core.sv]
// PC sequencing, 16-level return stack and indirect pointer decoding.
// Assumes the decode logic gives one-cycle op strobes on clk_sys_i and
// owns the data memories; this block only forms addresses.
//
// Decided for this implementation: register access over APB.
`timescale 1ns/1ns
// What this block does
// - PC is 15 bits, high from latch
// - Every reset clears the whole PC
// - Writing PC low byte loads latch high
// - Call loads operand, high bits 6:3 latch
// - Computed call: low from accumulator, high latch
// - Accumulator branch: PC+1 plus unsigned accumulator
// - Operand branch: PC+1 plus signed operand
// - Sixteen entry, 15-bit separate return stack
// - Push on calls/interrupt, pop on returns
// - Without fault reset, stack wraps circularly
// - Overflow and underflow always set flags
// - Five-bit pointer selects top-of-stack window
// - Push increments then writes; pop reads then decrements
// - Fault reset option resets on overflow/underflow
// - Indirect to indirect port reads zero, no write
// - Pointer is 16 bits from two bytes
// - Up to 0xFFF maps to absolute data
// - Linear region maps banked 80-byte blocks
// - Unimplemented linear memory reads zero
// - Top bit set addresses program memory low byte
// - Program memory access adds cycle, no write
// - Fault reset option is a config bit
module pcs_core
   import pcs_pkg::*;
#(
   parameter int LIN_BANKS = 32
)(
   // Clock and reset
   input  wire logic        clk_sys_i,
   input  wire logic        resetn_i,
   // APB slave
   input  wire logic        psel_i,
   input  wire logic        penable_i,
   input  wire logic        pwrite_i,
   input  wire logic [13:0] paddr_i,
   input  wire logic [31:0] pwdata_i,
   output logic [31:0]      prdata_o,
   output logic             pready_o,
   output logic             pslverr_o,
   // Sequencing from decode
   input  wire logic [2:0]  op_i,
   input  wire logic [10:0] operand_i,
   input  wire logic [7:0]  accum_i,
   input  wire logic        pc_inc_i,
   input  wire logic [7:0]  pc_low_wdata_i,
   input  wire logic [15:0] ptr0_i,
   input  wire logic [15:0] ptr1_i,
   // Indirect decode request
   input  wire logic        ind_sel_i,
   input  wire logic        ind_wr_i,
   // Outputs
   output logic [14:0]      pc_o,
   output logic [14:0]      ret_addr_o,
   output logic             fault_reset_o,
   output logic [1:0]       ind_region_o,
   output logic [15:0]      ind_addr_o,
   output logic             ind_zero_o,
   output logic             ind_wr_en_o,
   output logic             ind_stall_o
);
   initial begin
      if (LIN_BANKS < 1 || LIN_BANKS > 32) $error("LIN_BANKS out of range");
   end

   logic [14:0] pc_reg;
   logic [7:0]  pc_latch_reg, latch_s_reg, p0l_s_reg, p0h_s_reg, p1l_s_reg, p1h_s_reg;
   logic [4:0]  sp_reg;
   logic [14:0] stk_mem [STK_DEPTH];
   logic        ovf_reg, unf_reg, cfg_reg;
   logic        push, pop, ovf_ev, unf_ev;
   logic [4:0]  sp_next;
   logic [14:0] pc_inc, pc_next;
   logic        apb_wr, apb_rd;

   assign apb_wr = psel_i && penable_i && pwrite_i;
   assign apb_rd = psel_i && !penable_i && !pwrite_i;
   assign push   = (op_i == PCS_OP_CALL) || (op_i == PCS_OP_CCALL)
                || (op_i == PCS_OP_IRQ);
   assign pop    = (op_i == PCS_OP_RET);
   assign pc_inc = pc_reg + 15'h0001;

   // Push overflows from entry 15; pop underflows from the empty mark
   assign ovf_ev = push && (sp_reg == 5'h0F);
   assign unf_ev = pop && (sp_reg == SP_RESET);

   always_comb begin
      pc_next = pc_reg;
      case (op_i)
         PCS_OP_PCLOW: pc_next = {pc_latch_reg[6:0], pc_low_wdata_i};
         PCS_OP_CALL:  pc_next = {pc_latch_reg[6:3], operand_i};
         PCS_OP_CCALL: pc_next = {pc_latch_reg[6:0], accum_i};
         PCS_OP_AJMP:  pc_next = pc_inc + {7'h00, accum_i};
         PCS_OP_SJMP:  pc_next = pc_inc + {{6{operand_i[8]}}, operand_i[8:0]};
         PCS_OP_RET:   pc_next = stk_mem[sp_reg[3:0]];
         PCS_OP_IRQ:   pc_next = 15'h0004;
         default:      pc_next = pc_inc_i ? pc_inc : pc_reg;
      endcase
   end

   // Program counter, cleared by every reset including stack faults
   always_ff @(posedge clk_sys_i) begin
      if (!resetn_i || fault_reset_o) begin
         pc_reg <= PC_RESET;
      end else if (apb_wr && paddr_i == ADDR_PC_LOW) begin
         pc_reg <= {pc_latch_reg[6:0], pwdata_i[7:0]};
      end else begin
         pc_reg <= pc_next;
      end
   end

   // Pointer wraps in 4 bits when the fault option is off
   always_comb begin
      sp_next = sp_reg;
      if (push) begin
         sp_next = (sp_reg == SP_RESET) ? 5'h00 : {1'b0, sp_reg[3:0] + 4'h1};
      end else if (pop) begin
         sp_next = (sp_reg == 5'h00) ? SP_RESET : {1'b0, sp_reg[3:0] - 4'h1};
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (!resetn_i || fault_reset_o) begin
         sp_reg <= SP_RESET;
      end else if (apb_wr && paddr_i == ADDR_STK_PTR) begin
         sp_reg <= pwdata_i[4:0];
      end else begin
         sp_reg <= sp_next;
      end
   end

   // Stack storage; no reset since contents are undefined at power-up
   always_ff @(posedge clk_sys_i) begin
      if (push) begin
         stk_mem[sp_next[3:0]] <= pc_reg;
      end else if (apb_wr && paddr_i == ADDR_TOS_LOW) begin
         stk_mem[sp_reg[3:0]][7:0] <= pwdata_i[7:0];
      end else if (apb_wr && paddr_i == ADDR_TOS_HIGH) begin
         stk_mem[sp_reg[3:0]][14:8] <= pwdata_i[6:0];
      end
   end

   // Flags: event wins over a software clear in the same cycle
   always_ff @(posedge clk_sys_i) begin
      if (!resetn_i) begin
         ovf_reg <= 1'b0;
         unf_reg <= 1'b0;
      end else begin
         if (ovf_ev) begin
            ovf_reg <= 1'b1;
         end else if (apb_wr && paddr_i == ADDR_STATUS && !pwdata_i[ST_OVF_BIT]) begin
            ovf_reg <= 1'b0;
         end
         if (unf_ev) begin
            unf_reg <= 1'b1;
         end else if (apb_wr && paddr_i == ADDR_STATUS && !pwdata_i[ST_UNF_BIT]) begin
            unf_reg <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (!resetn_i) begin
         fault_reset_o <= 1'b0;
      end else begin
         fault_reset_o <= cfg_reg && (ovf_ev || unf_ev);
      end
   end

   // Config bit and latch; push/pop never touch the latch
   always_ff @(posedge clk_sys_i) begin
      if (!resetn_i) begin
         cfg_reg      <= CFG_RESET;
         pc_latch_reg <= 8'h00;
      end else if (apb_wr) begin
         if (paddr_i == ADDR_CFG) cfg_reg <= pwdata_i[0];
         if (paddr_i == ADDR_PC_LATCH) pc_latch_reg <= {1'b0, pwdata_i[6:0]};
      end
   end

   // Shadows captured at interrupt entry, also software-writable
   always_ff @(posedge clk_sys_i) begin
      if (!resetn_i) begin
         latch_s_reg  <= 8'h00;
         p0l_s_reg    <= 8'h00;
         p0h_s_reg    <= 8'h00;
         p1l_s_reg    <= 8'h00;
         p1h_s_reg    <= 8'h00;
      end else if (op_i == PCS_OP_IRQ) begin
         latch_s_reg  <= pc_latch_reg;
         p0l_s_reg    <= ptr0_i[7:0];
         p0h_s_reg    <= ptr0_i[15:8];
         p1l_s_reg    <= ptr1_i[7:0];
         p1h_s_reg    <= ptr1_i[15:8];
      end else if (apb_wr) begin
         case (paddr_i)
            ADDR_LATCH_S:  latch_s_reg  <= pwdata_i[7:0];
            ADDR_P0L_S:    p0l_s_reg    <= pwdata_i[7:0];
            ADDR_P0H_S:    p0h_s_reg    <= pwdata_i[7:0];
            ADDR_P1L_S:    p1l_s_reg    <= pwdata_i[7:0];
            ADDR_P1H_S:    p1h_s_reg    <= pwdata_i[7:0];
            default:       ;
         endcase
      end
   end

   // APB: zero wait states, read data registered in setup cycle
   always_ff @(posedge clk_sys_i) begin
      if (!resetn_i) begin
         prdata_o  <= 32'h0000_0000;
         pready_o  <= 1'b0;
         pslverr_o <= 1'b0;
      end else begin
         pready_o  <= psel_i && !penable_i;
         pslverr_o <= 1'b0;
         if (apb_rd) begin
            case (paddr_i)
               ADDR_STK_PTR:  prdata_o <= {27'h0, sp_reg};
               ADDR_TOS_LOW:  prdata_o <= {24'h0, stk_mem[sp_reg[3:0]][7:0]};
               ADDR_TOS_HIGH: prdata_o <= {25'h0, stk_mem[sp_reg[3:0]][14:8]};
               ADDR_PC_LOW:   prdata_o <= {24'h0, pc_reg[7:0]};
               ADDR_PC_LATCH: prdata_o <= {24'h0, pc_latch_reg};
               ADDR_LATCH_S:  prdata_o <= {24'h0, latch_s_reg};
               ADDR_P0L_S:    prdata_o <= {24'h0, p0l_s_reg};
               ADDR_P0H_S:    prdata_o <= {24'h0, p0h_s_reg};
               ADDR_P1L_S:    prdata_o <= {24'h0, p1l_s_reg};
               ADDR_P1H_S:    prdata_o <= {24'h0, p1h_s_reg};
               ADDR_STATUS:   prdata_o <= {30'h0, unf_reg, ovf_reg};
               ADDR_CFG:      prdata_o <= {31'h0, cfg_reg};
               default: begin
                  prdata_o  <= 32'h0000_0000;
                  pslverr_o <= 1'b1;
               end
            endcase
         end
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (!resetn_i) begin
         ret_addr_o <= 15'h0000;
      end else begin
         ret_addr_o <= stk_mem[sp_reg[3:0]];
      end
   end

   // Mirrors pc_reg so fault resets and software loads show at once
   always_ff @(posedge clk_sys_i) begin
      if (!resetn_i || fault_reset_o) begin
         pc_o <= PC_RESET;
      end else if (apb_wr && paddr_i == ADDR_PC_LOW) begin
         pc_o <= {pc_latch_reg[6:0], pwdata_i[7:0]};
      end else begin
         pc_o <= pc_next;
      end
   end

   // Indirect decode: ptr0 when ind_sel_i low, ptr1 when high
   logic [15:0] ptr;
   logic [15:0] lin_ofs;
   logic [4:0]  lin_bank;
   logic [6:0]  lin_low;
   logic [1:0]  reg_n;
   logic [15:0] adr_n;
   logic        zero_n, wr_n;
   logic        pm_wait_reg;

   assign ptr      = ind_sel_i ? ptr1_i : ptr0_i;
   assign lin_ofs  = ptr - LIN_BASE;
   assign lin_bank = 5'(lin_ofs / 16'd80);
   assign lin_low  = 7'(lin_ofs % 16'd80);

   always_comb begin
      reg_n  = PCS_REG_NONE;
      adr_n  = 16'h0000;
      zero_n = 1'b1;
      wr_n   = 1'b0;
      if (ptr[15]) begin
         reg_n = PCS_REG_PM;
         adr_n = {1'b0, ptr[14:0]};
         zero_n = 1'b0;
      end else if (ptr <= TRAD_TOP) begin
         reg_n  = PCS_REG_TRAD;
         adr_n  = ptr;
         zero_n = (ptr[6:0] == IND0_ADR) || (ptr[6:0] == IND1_ADR);
         wr_n   = ind_wr_i && !zero_n;
      end else if (ptr >= LIN_BASE && ptr <= LIN_TOP
                   && {11'h0, lin_bank} < 16'(LIN_BANKS)) begin
         reg_n  = PCS_REG_LIN;
         adr_n  = {4'h0, lin_bank, lin_low + RAM_OFS};
         zero_n = 1'b0;
         wr_n   = ind_wr_i;
      end
      // Other addresses read zero, writes dropped
   end

   always_ff @(posedge clk_sys_i) begin
      if (!resetn_i) begin
         ind_region_o <= PCS_REG_NONE;
         ind_addr_o   <= 16'h0000;
         ind_zero_o   <= 1'b0;
         ind_wr_en_o  <= 1'b0;
         ind_stall_o  <= 1'b0;
         pm_wait_reg  <= 1'b0;
      end else begin
         ind_region_o <= reg_n;
         ind_addr_o   <= adr_n;
         ind_zero_o   <= zero_n;
         ind_wr_en_o  <= wr_n;
         pm_wait_reg  <= ptr[15] && !pm_wait_reg;
         ind_stall_o  <= ptr[15] && !pm_wait_reg;
      end
   end

   stk_ovf_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
      ovf_ev |=> ovf_reg && (fault_reset_o == $past(cfg_reg)))
      else $error("overflow not flagged");
   pc_reset_a: assert property (@(posedge clk_sys_i)
      !resetn_i |=> pc_reg == 15'h0000)
      else $error("pc not cleared");
   call_load_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
      (op_i == PCS_OP_CALL) && !fault_reset_o && !apb_wr
      |=> pc_reg == {$past(pc_latch_reg[6:3]), $past(operand_i)})
      else $error("call target wrong");
   push_inc_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
      push && sp_reg < 5'h0F && !apb_wr && !fault_reset_o
      |=> sp_reg == $past(sp_reg) + 5'h01)
      else $error("push pointer wrong");
   push_ret_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
      push && !fault_reset_o |=> stk_mem[sp_reg[3:0]] == $past(pc_reg))
      else $error("pushed value wrong");
   ajmp_load_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
      (op_i == PCS_OP_AJMP) && !apb_wr && !fault_reset_o
      |=> pc_reg == $past(pc_reg) + 15'h0001 + {7'h00, $past(accum_i)})
      else $error("accumulator branch target wrong");
   latch_keep_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
      (push || pop) && !apb_wr |=> $stable(pc_latch_reg))
      else $error("latch changed by stack");
   ind_self_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
      !ptr[15] && ptr <= TRAD_TOP && ptr[6:1] == 6'h00 |=> ind_zero_o && !ind_wr_en_o)
      else $error("indirect self access");
   pm_wr_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
      ptr[15] |=> !ind_wr_en_o && ind_region_o == PCS_REG_PM)
      else $error("program memory write");
endmodule : pcs_core

// [tb/pcs_cpu_model.sv]
// Decode and execute model: one-cycle op strobes and live pointers.
// Assumes one caller process and the core's clock.
`timescale 1ns/1ns
module pcs_cpu_model (
   // Clock
   input  wire logic   clk_i,
   // To the core
   output logic [2:0]  op_o,
   output logic [10:0] operand_o,
   output logic [7:0]  accum_o,
   output logic        pc_inc_o,
   output logic [7:0]  pc_low_wdata_o,
   output logic [15:0] ptr0_o,
   output logic [15:0] ptr1_o,
   output logic        ind_sel_o,
   output logic        ind_wr_o
);
   initial begin
      {op_o, operand_o, accum_o, pc_inc_o, pc_low_wdata_o} = '0;
      {ptr0_o, ptr1_o, ind_sel_o, ind_wr_o} = '0;
   end

   // One op per cycle; an idle op advances the PC once
   task automatic issue(input logic [2:0] op, input logic [10:0] arg,
                        input logic [7:0] acc);
      @(posedge clk_i);
      op_o        <= op;
      operand_o   <= arg;
      accum_o     <= acc;
      pc_low_wdata_o <= acc;
      pc_inc_o    <= (op == 3'h0);
      @(posedge clk_i);
      op_o     <= 3'h0;
      pc_inc_o <= 1'b0;
      // Let the edge's updates settle before the caller looks
      #1;
   endtask : issue

   // Unselected pointer carries the inverse so a wrong select shows
   task automatic point(input logic [15:0] p, input logic sel, input logic wr);
      @(posedge clk_i);
      ptr0_o    <= sel ? ~p : p;
      ptr1_o    <= sel ? p : ~p;
      ind_sel_o <= sel;
      ind_wr_o  <= wr;
   endtask : point
endmodule : pcs_cpu_model

// [tb/pcs_core_bench.sv]
// Self-checking bench for the PC, return stack and pointer decode core.
// Assumes zero-wait APB answers and registered decode outputs.
`timescale 1ns/1ns
module pcs_core_bench import pcs_pkg::*; ;
   logic        clk, resetn, psel, penable, pwrite, pready, pslverr;
   logic [13:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [2:0]  op;
   logic [10:0] operand;
   logic [7:0]  accum, pc_low_wdata;
   logic        pc_inc, ind_sel, ind_wr, fault, izero, iwren, istall, err;
   logic [15:0] ptr0, ptr1, iaddr;
   logic [14:0] pc, ret_addr;
   logic [1:0]  region;
   int          fail_count = 0;
   int          cmp_count = 0;
   // Decode table: pointer, expected address and region per entry
   logic [15:0] ip [6] = '{16'h0123, 16'h0081, 16'h0001, 16'h2050, 16'h29AF, 16'h8005};
   logic [15:0] ia [6] = '{16'h0123, 16'h0081, 16'h0001, 16'h00A0, 16'h0000, 16'h0005};
   logic [1:0]  ir [6] = '{2'h0, 2'h0, 2'h0, 2'h1, 2'h2, 2'h3};
   logic [5:0]  isel = 6'b101010;
   logic [5:0]  iwr  = 6'b100101;
   logic [5:0]  iz   = 6'b010010;
   logic [5:0]  ie   = 6'b000001;
   logic [5:0]  is   = 6'b100000;

   pcs_cpu_model cpu (.clk_i(clk), .op_o(op), .operand_o(operand), .accum_o(accum),
      .pc_inc_o(pc_inc), .pc_low_wdata_o(pc_low_wdata), .ptr0_o(ptr0), .ptr1_o(ptr1),
      .ind_sel_o(ind_sel), .ind_wr_o(ind_wr));

   // Few banks so the top of the linear region is unimplemented
   pcs_core #(.LIN_BANKS(4)) uut (.clk_sys_i(clk), .resetn_i(resetn),
      .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
      .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
      .op_i(op), .operand_i(operand), .accum_i(accum), .pc_inc_i(pc_inc),
      .pc_low_wdata_i(pc_low_wdata), .ptr0_i(ptr0), .ptr1_i(ptr1), .ind_sel_i(ind_sel),
      .ind_wr_i(ind_wr), .pc_o(pc), .ret_addr_o(ret_addr), .fault_reset_o(fault),
      .ind_region_o(region), .ind_addr_o(iaddr), .ind_zero_o(izero),
      .ind_wr_en_o(iwren), .ind_stall_o(istall));

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task automatic stop_test;
      if (fail_count == 0 && cmp_count > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : stop_test

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         fail_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // Request held until pready is seen at a rising edge
   task automatic apb(input logic wr, input logic [13:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      psel    <= 1'b1;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1 && n < 20) begin
         n++;
         @(posedge clk);
      end
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic rchk(input logic [13:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(rd, exp);
   endtask : rchk

   task automatic t_reset;
      rchk(ADDR_STK_PTR, 32'h1F);
      rchk(ADDR_PC_LOW, 32'h0);
      rchk(ADDR_CFG, 32'h0);
      rchk(ADDR_STATUS, 32'h0);
      chk(32'(pc), 32'h0);
      apb(1'b0, 14'h0030, 32'h0);
      chk({31'h0, err}, 32'h1);
   endtask : t_reset

   task automatic t_pcload;
      apb(1'b1, ADDR_PC_LATCH, 32'h55);
      cpu.issue(PCS_OP_PCLOW, 11'h0, 8'hA7);
      chk(32'(pc), 32'h55A7);
      cpu.issue(PCS_OP_CALL, 11'h3C1, 8'h0);
      chk(32'(pc), 32'h53C1);
      cpu.issue(PCS_OP_CCALL, 11'h0, 8'h3E);
      chk(32'(pc), 32'h553E);
      cpu.issue(PCS_OP_AJMP, 11'h0, 8'hFF);
      chk(32'(pc), 32'h563E);
      cpu.issue(PCS_OP_SJMP, 11'h1F0, 8'h0);
      chk(32'(pc), 32'h562F);
      cpu.issue(PCS_OP_NONE, 11'h0, 8'h0);
      chk(32'(pc), 32'h5630);
      rchk(ADDR_PC_LOW, 32'h30);
      rchk(ADDR_STK_PTR, 32'h01);
   endtask : t_pcload

   task automatic t_tos;
      apb(1'b1, ADDR_STK_PTR, 32'h05);
      apb(1'b1, ADDR_TOS_LOW, 32'h34);
      apb(1'b1, ADDR_TOS_HIGH, 32'h12);
      rchk(ADDR_TOS_LOW, 32'h34);
      rchk(ADDR_TOS_HIGH, 32'h12);
      chk(32'(ret_addr), 32'h1234);
      cpu.issue(PCS_OP_RET, 11'h0, 8'h0);
      chk(32'(pc), 32'h1234);
      rchk(ADDR_STK_PTR, 32'h04);
      rchk(ADDR_PC_LATCH, 32'h55);
   endtask : t_tos

   task automatic t_stack;
      apb(1'b1, ADDR_STK_PTR, 32'h1F);
      for (int i = 0; i < 16; i++) begin
         cpu.issue(PCS_OP_CALL, 11'(i), 8'h0);
      end
      rchk(ADDR_STK_PTR, 32'h0F);
      rchk(ADDR_STATUS, 32'h0);
      cpu.issue(PCS_OP_CALL, 11'h0, 8'h0);
      rchk(ADDR_STK_PTR, 32'h00);
      rchk(ADDR_STATUS, 32'h1);
      apb(1'b1, ADDR_STATUS, 32'h0);
      rchk(ADDR_STATUS, 32'h0);
      apb(1'b1, ADDR_STK_PTR, 32'h1F);
      cpu.issue(PCS_OP_RET, 11'h0, 8'h0);
      rchk(ADDR_STATUS, 32'h2);
   endtask : t_stack

   // Overflow then underflow with the fault reset option on
   task automatic t_fault;
      logic seen;
      apb(1'b1, ADDR_CFG, 32'h1);
      for (int k = 0; k < 2; k++) begin
         seen = 1'b0;
         apb(1'b1, ADDR_STATUS, 32'h0);
         apb(1'b1, ADDR_STK_PTR, k ? 32'h1F : 32'h0F);
         cpu.issue(k ? PCS_OP_RET : PCS_OP_CALL, 11'h0, 8'h0);
         repeat (3) begin
            #1;
            seen = seen | (fault === 1'b1);
            @(posedge clk);
         end
         chk({31'h0, seen}, 32'h1);
         #1;
         chk(32'(pc), 32'h0);
         rchk(ADDR_STK_PTR, 32'h1F);
         rchk(ADDR_STATUS, k ? 32'h2 : 32'h1);
      end
      apb(1'b1, ADDR_CFG, 32'h0);
   endtask : t_fault

   task automatic t_ind;
      for (int k = 0; k < 6; k++) begin
         cpu.point(ip[k], isel[k], iwr[k]);
         @(posedge clk);
         #1;
         chk(32'(region), 32'(ir[k]));
         chk(32'(iaddr), 32'(ia[k]));
         chk(32'(iwren), 32'(ie[k]));
         chk(32'(istall), 32'(is[k]));
         if (!iwr[k]) chk(32'(izero), 32'(iz[k]));
      end
      @(posedge clk);
      #1;
      chk(32'(istall), 32'h0);
   endtask : t_ind

   initial begin
      {psel, penable, pwrite, paddr, pwdata} = '0;
      resetn = 1'b0;
      repeat (5) @(posedge clk);
      resetn <= 1'b1;
      t_reset();
      t_pcload();
      t_tos();
      t_stack();
      t_fault();
      t_ind();
      stop_test();
   end

   // Whole run needs a few hundred cycles at most
   initial begin
      #500000;
      fail_count++;
      stop_test();
   end
endmodule : pcs_core_bench
